// File: design/srx_clk_if.sv
`timescale 1ns/10ps
interface srx_clk_if;
    logic [1:0] clk_sel;
    logic       rx_run;
    logic       tmr_tick;
    logic       rx_tick;
    logic       tx_tick;

    modport gen (input clk_sel, input rx_run, input tmr_tick, output rx_tick, output tx_tick);
    modport use_side (output clk_sel, output rx_run, output tmr_tick, input rx_tick, input tx_tick);
endinterface

// File: design/srx_clkgen.sv
`timescale 1ns/10ps
module srx_clkgen
    import srx_pkg::*;
#(
    parameter int CNT_W = 4
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Shift clock selection and ticks
    srx_clk_if.gen   cif
);

    if (CNT_W < 4)
    begin : g_chk
        $error("srx_clkgen: CNT_W too small for the divide by 16.");
    end

    logic [CNT_W-1:0] rx_cnt_ff;
    logic [CNT_W-1:0] tx_cnt_ff;
    logic             is_timer;

    // Start detect and tick register add two cycles ahead of the first tick.
    localparam logic [CNT_W-1:0] START_LAT = CNT_W'(2);

    // ============================================================
    // Divider terminal count for each source.
    function automatic logic [CNT_W-1:0] last_of(input logic [1:0] sel);
        case (sel)
            CLK_DIV4: last_of = CNT_W'(DIV4_LAST);
            CLK_DIV8: last_of = CNT_W'(DIV8_LAST);
            default:  last_of = CNT_W'(DIV16_LAST);
        endcase
    endfunction

    assign is_timer = (cif.clk_sel == CLK_TIMER);

    // ============================================================
    // With a divider source, the receive shift clock restarts half a bit into each start bit, so ticks land mid-bit.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rx_cnt_ff   <= '0;
            cif.rx_tick <= 1'b0;
        end
        else if (!cif.rx_run)
        begin
            rx_cnt_ff   <= (last_of(cif.clk_sel) >> 1) + START_LAT;
            cif.rx_tick <= 1'b0;
        end
        else if (is_timer)
        begin
            rx_cnt_ff   <= '0;
            cif.rx_tick <= cif.tmr_tick;
        end
        else if (rx_cnt_ff == last_of(cif.clk_sel))
        begin
            rx_cnt_ff   <= '0;
            cif.rx_tick <= 1'b1;
        end
        else
        begin
            rx_cnt_ff   <= rx_cnt_ff + 1'b1;
            cif.rx_tick <= 1'b0;
        end
    end

    // ============================================================
    // Transmit shift clock runs free.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tx_cnt_ff   <= '0;
            cif.tx_tick <= 1'b0;
        end
        else if (is_timer)
        begin
            tx_cnt_ff   <= '0;
            cif.tx_tick <= cif.tmr_tick;
        end
        else if (tx_cnt_ff == last_of(cif.clk_sel))
        begin
            tx_cnt_ff   <= '0;
            cif.tx_tick <= 1'b1;
        end
        else
        begin
            tx_cnt_ff   <= tx_cnt_ff + 1'b1;
            cif.tx_tick <= 1'b0;
        end
    end

endmodule // srx_clkgen

// File: design/srx_pkg.sv
package srx_pkg;

    // ============================================================
    // Register addresses
    localparam logic [15:0] SRX_ADDR_MODE = 16'hFF48;
    localparam logic [15:0] SRX_ADDR_CTRL = 16'hFF49;
    localparam logic [15:0] SRX_ADDR_DATA = 16'hFF4A;
    localparam logic [15:0] SRX_ADDR_IEN  = 16'hFF23;
    localparam logic [15:0] SRX_ADDR_IFAC = 16'hFF25;
    localparam logic [15:0] SRX_ADDR_PRIO = 16'hFF21;

    // ============================================================
    // Field positions
    localparam int MODE_PIN     = 0;
    localparam int MODE_LINK_LO = 1;
    localparam int MODE_CLK_LO  = 3;
    localparam int MODE_ODD     = 5;
    localparam int MODE_PAR     = 6;
    localparam int CTRL_TRANSMIT_ENABLE_BIT    = 0;
    localparam int CTRL_TRANSMIT_TRIGGER_BIT   = 1;
    localparam int CTRL_RECEIVE_ENABLE_BIT    = 2;
    localparam int CTRL_RECEIVE_TRIGGER_BIT   = 3;
    localparam int CTRL_OER     = 4;
    localparam int CTRL_PER     = 5;
    localparam int CTRL_FER     = 6;
    localparam int IRQ_TX       = 0;
    localparam int IRQ_RX       = 1;
    localparam int IRQ_ERR      = 2;

    // ============================================================
    // Reset values and codes
    localparam logic [7:0] MODE_RST   = 8'h00;
    localparam logic [7:0] TX_BUF_RST = 8'hFF;
    localparam logic [1:0] CLK_TIMER  = 2'h3;
    localparam logic [1:0] CLK_DIV4   = 2'h2;
    localparam logic [1:0] CLK_DIV8   = 2'h1;
    localparam logic [3:0] DIV4_LAST  = 4'h3;
    localparam logic [3:0] DIV8_LAST  = 4'h7;
    localparam logic [3:0] DIV16_LAST = 4'hF;
    localparam logic [3:0] DATA7_BITS = 4'h7;
    localparam logic [3:0] DATA8_BITS = 4'h8;
    localparam logic [23:0] VEC_ERR   = 24'h000010;
    localparam logic [23:0] VEC_RX    = 24'h000012;
    localparam logic [23:0] VEC_TX    = 24'h000014;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } srx_rx_state_t;

endpackage

// File: design/srx_top.sv
`timescale 1ns/10ps
module srx_top
    import srx_pkg::*;
#(
    parameter int ADDR_W = 16
)
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // Register port
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [7:0]        wdata,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    output wire logic [7:0]        rdata,
    // Serial pins
    input  wire logic              serial_rx_line,
    output wire logic              serial_tx_line,
    output wire logic              serial_pin_select,
    input  wire logic              tmr_tick,
    // Interrupt request
    input  wire logic [1:0]        cpu_mask_level,
    output wire logic              irq_req,
    output wire logic [23:0]       irq_vector,
    output wire logic [1:0]        irq_level
);

    if (ADDR_W < 16)
    begin : g_chk
        $error("srx_top: ADDR_W below 16 cannot reach the registers.");
    end

    srx_rx_state_t rx_state_ff;
    logic [7:0]    mode_ff;
    logic          transmit_enable_bit_ff;
    logic          receive_enable_bit_ff;
    logic          rx_ready_ff;
    logic          per_ff;
    logic          oer_ff;
    logic          fer_ff;
    logic [2:0]    ien_ff;
    logic [2:0]    ifac_ff;
    logic [1:0]    prio_ff;
    logic [7:0]    rx_buf_ff;
    logic [7:0]    tx_buf_ff;
    logic [8:0]    rx_sh_ff;
    logic [3:0]    rx_cnt_ff;
    logic [10:0]   tx_sh_ff;
    logic [3:0]    tx_cnt_ff;
    logic          tx_busy_ff;
    logic          tx_line_ff;
    logic [7:0]    rdata_ff;
    logic          irq_req_ff;
    logic [23:0]   irq_vector_ff;
    logic [1:0]    irq_level_ff;
    logic          wr_mode;
    logic          wr_ctrl;
    logic          wr_trg;
    logic          async_md;
    logic          par_on;
    logic          rx_on;
    logic [3:0]    data_bits;
    logic [3:0]    frame_bits;
    logic          xfer;
    logic          stop_bad;
    logic          par_bad;
    logic          ovr;
    logic          tx_ev;
    logic          clr_all;
    logic [2:0]    pend;
    logic [10:0]   tx_frame;
    logic [8:0]    tx_pay;

    srx_clk_if cif ();

    // ============================================================
    // Register decode.
    function automatic logic wr_hit(input logic [15:0] a);
        wr_hit = wr_en && (addr == ADDR_W'(a));
    endfunction

    assign wr_mode    = wr_hit(SRX_ADDR_MODE);
    assign wr_ctrl    = wr_hit(SRX_ADDR_CTRL);
    assign wr_trg     = wr_ctrl && wdata[CTRL_RECEIVE_TRIGGER_BIT];
    assign clr_all    = wr_ctrl && !wdata[CTRL_RECEIVE_ENABLE_BIT];
    assign async_md   = mode_ff[MODE_LINK_LO+1];
    assign par_on     = async_md && mode_ff[MODE_PAR];
    assign rx_on      = receive_enable_bit_ff && async_md && mode_ff[MODE_PIN];
    assign data_bits  = mode_ff[MODE_LINK_LO] ? DATA8_BITS : DATA7_BITS;
    assign frame_bits = data_bits + {3'h0, par_on};

    // ============================================================
    // Shift clock generator.
    assign cif.clk_sel  = mode_ff[MODE_CLK_LO +: 2];
    assign cif.rx_run   = (rx_state_ff != RX_IDLE);
    assign cif.tmr_tick = tmr_tick;

    srx_clkgen #(
        .CNT_W (4)
    ) u_clkgen (
        .clk  (clk),
        .rstn (rstn),
        .cif  (cif)
    );

    // ============================================================
    // Receive character events.
    assign xfer     = (rx_state_ff == RX_STOP) && rx_on && cif.rx_tick;
    assign stop_bad = !serial_rx_line;
    assign par_bad  = par_on && ((^rx_sh_ff) ^ mode_ff[MODE_ODD]);
    assign ovr      = xfer && (!rx_ready_ff || wr_trg);

    // ============================================================
    // Receive state machine.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rx_state_ff <= RX_IDLE;
            rx_cnt_ff   <= 4'h0;
            rx_sh_ff    <= 9'h000;
        end
        else if (!rx_on)
        begin
            rx_state_ff <= RX_IDLE;
        end
        else
        begin
            case (rx_state_ff)
                RX_IDLE:
                begin
                    if (!serial_rx_line)
                    begin
                        rx_state_ff <= RX_START;
                        rx_cnt_ff   <= 4'h0;
                        rx_sh_ff    <= 9'h000;
                    end
                end
                RX_START:
                begin
                    if (cif.rx_tick)
                    begin
                        rx_state_ff <= RX_DATA;
                    end
                end
                RX_DATA:
                begin
                    if (cif.rx_tick)
                    begin
                        rx_sh_ff[rx_cnt_ff] <= serial_rx_line;
                        rx_cnt_ff           <= rx_cnt_ff + 4'h1;
                        if (rx_cnt_ff == frame_bits - 4'h1)
                        begin
                            rx_state_ff <= RX_STOP;
                        end
                    end
                end
                RX_STOP:
                begin
                    if (cif.rx_tick)
                    begin
                        rx_state_ff <= RX_IDLE;
                    end
                end
                default:
                begin
                    rx_state_ff <= RX_IDLE;
                end
            endcase
        end
    end

    // ============================================================
    // Receive buffer and buffer-empty handshake.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rx_buf_ff <= 8'h00;
        end
        else if (xfer)
        begin
            rx_buf_ff <= mode_ff[MODE_LINK_LO] ? rx_sh_ff[7:0] : {1'b0, rx_sh_ff[6:0]};
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rx_ready_ff <= 1'b0;
        end
        else if (clr_all || xfer)
        begin
            rx_ready_ff <= 1'b0;
        end
        else if (wr_trg || (wr_ctrl && !receive_enable_bit_ff))
        begin
            rx_ready_ff <= 1'b1;
        end
    end

    // ============================================================
    // Error flags; a set in the clearing cycle wins.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            per_ff <= 1'b0;
            oer_ff <= 1'b0;
            fer_ff <= 1'b0;
        end
        else
        begin
            per_ff <= (xfer && par_bad) || (per_ff && !clr_all && !(wr_ctrl && wdata[CTRL_PER]));
            oer_ff <= ovr || (oer_ff && !clr_all && !(wr_ctrl && wdata[CTRL_OER]));
            fer_ff <= (xfer && stop_bad) || (fer_ff && !clr_all && !(wr_ctrl && wdata[CTRL_FER]));
        end
    end

    // ============================================================
    // Interrupt factors and request.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ifac_ff <= 3'h0;
        end
        else
        begin
            ifac_ff[IRQ_ERR] <= (xfer && (par_bad || stop_bad || ovr)) ||
                                (ifac_ff[IRQ_ERR] && !(wr_hit(SRX_ADDR_IFAC) && wdata[IRQ_ERR]));
            ifac_ff[IRQ_RX]  <= (xfer && !ovr) ||
                                (ifac_ff[IRQ_RX] && !(wr_hit(SRX_ADDR_IFAC) && wdata[IRQ_RX]));
            ifac_ff[IRQ_TX]  <= tx_ev ||
                                (ifac_ff[IRQ_TX] && !(wr_hit(SRX_ADDR_IFAC) && wdata[IRQ_TX]));
        end
    end

    assign pend = ifac_ff & ien_ff;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            irq_req_ff    <= 1'b0;
            irq_vector_ff <= 24'h000000;
            irq_level_ff  <= 2'h0;
        end
        else
        begin
            irq_req_ff   <= (|pend) && (prio_ff > cpu_mask_level);
            irq_level_ff <= prio_ff;
            if (pend[IRQ_ERR])
                irq_vector_ff <= VEC_ERR;
            else if (pend[IRQ_RX])
                irq_vector_ff <= VEC_RX;
            else
                irq_vector_ff <= VEC_TX;
        end
    end

    // ============================================================
    // Control registers.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mode_ff   <= MODE_RST;
            transmit_enable_bit_ff   <= 1'b0;
            receive_enable_bit_ff   <= 1'b0;
            ien_ff    <= 3'h0;
            prio_ff   <= 2'h0;
            tx_buf_ff <= TX_BUF_RST;
        end
        else
        begin
            if (wr_mode)
                mode_ff <= {1'b0, wdata[6:0]};
            if (wr_ctrl)
            begin
                transmit_enable_bit_ff <= wdata[CTRL_TRANSMIT_ENABLE_BIT];
                receive_enable_bit_ff <= wdata[CTRL_RECEIVE_ENABLE_BIT];
            end
            if (wr_hit(SRX_ADDR_IEN))
                ien_ff <= wdata[2:0];
            if (wr_hit(SRX_ADDR_PRIO))
                prio_ff <= wdata[1:0];
            if (wr_hit(SRX_ADDR_DATA))
                tx_buf_ff <= wdata;
        end
    end

    // ============================================================
    // Transmit frame build and shifter.
    always_comb
    begin
        tx_pay = {1'b0, tx_buf_ff};
        if (!mode_ff[MODE_LINK_LO])
            tx_pay[7] = 1'b0;
        if (par_on)
            tx_pay[data_bits] = (^tx_pay) ^ mode_ff[MODE_ODD];
        tx_frame = {11{1'b1}};
        tx_frame[0] = 1'b0;
        for (int i = 0; i < 9; i++)
        begin
            if (4'(i) < frame_bits)
                tx_frame[i+1] = tx_pay[i];
        end
    end

    assign tx_ev = tx_busy_ff && cif.tx_tick && (tx_cnt_ff == frame_bits + 4'h2);

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tx_busy_ff <= 1'b0;
            tx_sh_ff   <= {11{1'b1}};
            tx_cnt_ff  <= 4'h0;
            tx_line_ff <= 1'b1;
        end
        else if (!transmit_enable_bit_ff)
        begin
            tx_busy_ff <= 1'b0;
            tx_line_ff <= 1'b1;
        end
        else if (!tx_busy_ff)
        begin
            if (wr_ctrl && wdata[CTRL_TRANSMIT_TRIGGER_BIT] && async_md)
            begin
                tx_busy_ff <= 1'b1;
                tx_sh_ff   <= tx_frame;
                tx_cnt_ff  <= 4'h0;
            end
        end
        else if (cif.tx_tick)
        begin
            tx_line_ff <= tx_sh_ff[0];
            tx_sh_ff   <= {1'b1, tx_sh_ff[10:1]};
            tx_cnt_ff  <= tx_cnt_ff + 4'h1;
            if (tx_ev)
                tx_busy_ff <= 1'b0;
        end
    end

    // ============================================================
    // Read port.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rdata_ff <= 8'h00;
        end
        else if (!rd_en)
        begin
            rdata_ff <= 8'h00;
        end
        else if (addr == ADDR_W'(SRX_ADDR_MODE))
            rdata_ff <= mode_ff;
        else if (addr == ADDR_W'(SRX_ADDR_CTRL))
            rdata_ff <= {1'b0, fer_ff, per_ff, oer_ff, rx_ready_ff, receive_enable_bit_ff, tx_busy_ff, transmit_enable_bit_ff};
        else if (addr == ADDR_W'(SRX_ADDR_DATA))
            rdata_ff <= rx_buf_ff;
        else if (addr == ADDR_W'(SRX_ADDR_IEN))
            rdata_ff <= {5'h00, ien_ff};
        else if (addr == ADDR_W'(SRX_ADDR_IFAC))
            rdata_ff <= {5'h00, ifac_ff};
        else if (addr == ADDR_W'(SRX_ADDR_PRIO))
            rdata_ff <= {6'h00, prio_ff};
        else
            rdata_ff <= 8'h00;
    end

    assign rdata             = rdata_ff;
    assign serial_tx_line    = tx_line_ff;
    assign serial_pin_select = mode_ff[MODE_PIN];
    assign irq_req           = irq_req_ff;
    assign irq_vector        = irq_vector_ff;
    assign irq_level         = irq_level_ff;

    // ============================================================
    // Checks.
    AST_RECEIVE_ENABLE_BIT_CLR: assert property (@(posedge clk) disable iff (!rstn)
        clr_all && !xfer |=> !per_ff && !oer_ff && !fer_ff && !receive_enable_bit_ff)
        else $error("Receive disable did not clear error flags.");

    AST_START_DET: assert property (@(posedge clk) disable iff (!rstn)
        rx_state_ff == RX_IDLE && rx_on && !serial_rx_line |=> rx_state_ff == RX_START ##1 cif.rx_run)
        else $error("Start bit did not start the receive clock.");

    AST_FRAME_ERR: assert property (@(posedge clk) disable iff (!rstn)
        xfer && stop_bad |=> fer_ff && ifac_ff[IRQ_ERR])
        else $error("Low stop bit did not flag framing error.");

    AST_RX_DONE: assert property (@(posedge clk) disable iff (!rstn)
        xfer && !ovr && mode_ff[MODE_LINK_LO] |=> ifac_ff[IRQ_RX] && rx_buf_ff == $past(rx_sh_ff[7:0]))
        else $error("Completed character not buffered or flagged.");

    AST_OVR_NO_DONE: assert property (@(posedge clk) disable iff (!rstn)
        xfer && ovr && !ifac_ff[IRQ_RX] |=> !ifac_ff[IRQ_RX] && oer_ff)
        else $error("Overrun character raised receive done.");

    AST_PAR_ERR: assert property (@(posedge clk) disable iff (!rstn)
        xfer && par_bad |=> per_ff && ifac_ff[IRQ_ERR])
        else $error("Parity mismatch not flagged.");

    AST_TRG_COLLIDE: assert property (@(posedge clk) disable iff (!rstn)
        xfer && wr_trg |=> oer_ff && !rx_ready_ff)
        else $error("Trigger write at transfer not seen as overrun.");

    AST_W1C_PER: assert property (@(posedge clk) disable iff (!rstn)
        wr_ctrl && wdata[CTRL_PER] && !xfer |=> !per_ff)
        else $error("Parity flag did not clear on write of one.");

    AST_TX_DONE: assert property (@(posedge clk) disable iff (!rstn)
        tx_ev |=> ifac_ff[IRQ_TX] && !tx_busy_ff && tx_line_ff)
        else $error("Transmit end did not set its factor.");

    AST_IRQ_GATE: assert property (@(posedge clk) disable iff (!rstn)
        irq_req_ff |-> $past(|(ifac_ff & ien_ff)) && $past(prio_ff) > $past(cpu_mask_level))
        else $error("Request raised without enabled factor and priority.");

endmodule // srx_top

// File: testbench/srx_peer.sv
`timescale 1ns/10ps
module srx_peer
#(
    parameter int BIT_CYC = 4
)
(
    // Clock
    input  wire logic clk,
    // Serial lines from and toward the device
    input  wire logic tx,
    output logic      line
);
    int bit_cyc = BIT_CYC;
    // ============================================================
    // Frame sender, line idles high.
    initial line = 1'b1;
    task automatic send(input logic [7:0] d, input int nb, input logic par, input logic odd,
                        input logic bad, input logic stop);
        logic q[$];
        int   k;
        q.push_back(1'b0);
        for (k = 0; k < nb; k++) q.push_back(d[k]);
        if (par) q.push_back(^(d & (nb == 8 ? 8'hFF : 8'h7F)) ^ odd ^ bad);
        q.push_back(stop);
        foreach (q[j]) repeat (bit_cyc) @(posedge clk) line <= q[j];
        repeat (bit_cyc) @(posedge clk) line <= 1'b1;
    endtask
    // ============================================================
    // Frame taker, samples each data bit in its middle.
    task automatic take(input int nb, output logic [7:0] d);
        d = 8'h00;
        @(negedge tx);
        repeat (bit_cyc / 2) @(posedge clk);
        for (int k = 0; k < nb; k++)
        begin
            repeat (bit_cyc) @(posedge clk);
            d[k] = tx;
        end
    endtask
endmodule // srx_peer

// File: testbench/srx_top_test.sv
`timescale 1ns/10ps
module srx_top_test import srx_pkg::*; ;
    // ============================================================
    // Bench signals
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wdata = 8'h00;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic [1:0]  mask = 2'h0;
    logic [7:0]  rdata;
    logic        rx_line, tx_line, pin_sel, irq_req;
    logic [23:0] irq_vector;
    logic [1:0]  irq_level;
    int          bad_count = 0;
    int          check_count = 0;
    int          i;
    logic [7:0]  rxd;
    always #2 clk = ~clk;
    srx_top u_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata(rdata), .serial_rx_line(rx_line), .serial_tx_line(tx_line), .serial_pin_select(pin_sel),
        .tmr_tick(1'b0), .cpu_mask_level(mask), .irq_req(irq_req), .irq_vector(irq_vector),
        .irq_level(irq_level));
    srx_peer #(.BIT_CYC(4)) u_peer (.clk(clk), .tx(tx_line), .line(rx_line));
    // ============================================================
    // Access tasks
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        check_count++;
        if (g !== e) begin bad_count++; $display("MISMATCH %s expected %h seen %h", nm, e, g); end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), e, rdata);
        @(posedge clk);
    endtask
    task automatic irq(input logic r, input logic [23:0] v);
        repeat (2) @(posedge clk);
        #1;
        chk("irq_req", r, irq_req);
        if (r) chk("irq_vector", v, irq_vector);
        @(posedge clk);
    endtask
    task automatic fr(input logic [7:0] d, input int nb, input logic p, input logic o, input logic b,
                      input logic s);
        u_peer.send(d, nb, p, o, b, s);
        repeat (3) @(posedge clk);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        #100000;
        bad_count++;
        report_and_stop();
    end
    // ============================================================
    // Test sequence
    initial
    begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(SRX_ADDR_MODE, MODE_RST);
        rd(SRX_ADDR_CTRL, 8'h00);
        wr(SRX_ADDR_MODE, 8'hFF);
        rd(SRX_ADDR_MODE, 8'h7F);
        chk("pin_sel", 1'b1, pin_sel);
        wr(SRX_ADDR_MODE, 8'h17);
        rd(SRX_ADDR_MODE, 8'h17);
        wr(SRX_ADDR_IEN, 8'h07);
        wr(SRX_ADDR_PRIO, 8'h03);
        wr(SRX_ADDR_CTRL, 8'h04);
        rd(SRX_ADDR_CTRL, 8'h0C);
        fr(8'hA5, 8, 1'b0, 1'b0, 1'b0, 1'b1);
        rd(SRX_ADDR_DATA, 8'hA5);
        rd(SRX_ADDR_IFAC, 8'h02);
        irq(1'b1, VEC_RX);
        mask <= 2'h3;
        irq(1'b0, VEC_RX);
        mask <= 2'h0;
        wr(SRX_ADDR_IEN, 8'h00);
        irq(1'b0, VEC_RX);
        rd(SRX_ADDR_IFAC, 8'h02);
        wr(SRX_ADDR_IEN, 8'h07);
        wr(SRX_ADDR_IFAC, 8'h02);
        rd(SRX_ADDR_IFAC, 8'h00);
        fr(8'h3C, 8, 1'b0, 1'b0, 1'b0, 1'b1);
        rd(SRX_ADDR_DATA, 8'h3C);
        rd(SRX_ADDR_CTRL, 8'h14);
        rd(SRX_ADDR_IFAC, 8'h04);
        irq(1'b1, VEC_ERR);
        wr(SRX_ADDR_CTRL, 8'h04);
        rd(SRX_ADDR_CTRL, 8'h14);
        wr(SRX_ADDR_CTRL, 8'h1C);
        rd(SRX_ADDR_CTRL, 8'h0C);
        wr(SRX_ADDR_IFAC, 8'h04);
        rd(SRX_ADDR_IFAC, 8'h00);
        fr(8'h5A, 8, 1'b0, 1'b0, 1'b0, 1'b0);
        rd(SRX_ADDR_CTRL, 8'h44);
        rd(SRX_ADDR_IFAC, 8'h06);
        rd(SRX_ADDR_DATA, 8'h5A);
        wr(SRX_ADDR_CTRL, 8'h00);
        rd(SRX_ADDR_CTRL, 8'h00);
        wr(SRX_ADDR_IFAC, 8'h07);
        wr(SRX_ADDR_CTRL, 8'h04);
        for (i = 0; i < 4; i++)
        begin
            wr(SRX_ADDR_MODE, {2'b01, i[0], 5'b10111});
            fr(8'h96, 8, 1'b1, i[0], i[1], 1'b1);
            rd(SRX_ADDR_CTRL, i[1] ? 8'h24 : 8'h04);
            rd(SRX_ADDR_IFAC, i[1] ? 8'h06 : 8'h02);
            rd(SRX_ADDR_DATA, 8'h96);
            wr(SRX_ADDR_CTRL, 8'h2C);
            wr(SRX_ADDR_IFAC, 8'h07);
        end
        for (i = 0; i < 2; i++)
        begin
            u_peer.bit_cyc = i ? 16 : 8;
            wr(SRX_ADDR_MODE, i ? 8'h07 : 8'h0F);
            fr(8'hC3, 8, 1'b0, 1'b0, 1'b0, 1'b1);
            rd(SRX_ADDR_DATA, 8'hC3);
            wr(SRX_ADDR_CTRL, 8'h0C);
        end
        u_peer.bit_cyc = 4;
        wr(SRX_ADDR_MODE, 8'h15);
        fr(8'hFF, 7, 1'b0, 1'b0, 1'b0, 1'b1);
        rd(SRX_ADDR_DATA, 8'h7F);
        wr(SRX_ADDR_IFAC, 8'h07);
        wr(SRX_ADDR_MODE, 8'h01);
        fr(8'h00, 8, 1'b0, 1'b0, 1'b0, 1'b1);
        rd(SRX_ADDR_IFAC, 8'h00);
        wr(SRX_ADDR_MODE, 8'h15);
        wr(SRX_ADDR_DATA, 8'h81);
        wr(SRX_ADDR_CTRL, 8'h05);
        fork
            u_peer.take(7, rxd);
            begin
                wr(SRX_ADDR_CTRL, 8'h07);
                rd(SRX_ADDR_CTRL, 8'h07);
            end
        join
        chk("tx_data", 8'h01, rxd);
        repeat (60) @(posedge clk);
        rd(SRX_ADDR_IFAC, 8'h01);
        irq(1'b1, VEC_TX);
        mask <= 2'h1;
        for (i = 0; i < 4; i++)
        begin
            wr(SRX_ADDR_PRIO, 8'(i));
            irq(i > 1, VEC_TX);
            chk("irq_level", 24'(i), irq_level);
        end
        wr(SRX_ADDR_CTRL, 8'h04);
        chk("tx_line", 1'b1, tx_line);
        wr(SRX_ADDR_CTRL, 8'h0C);
        wr(SRX_ADDR_IFAC, 8'h07);
        fork
            u_peer.send(8'h55, 7, 1'b0, 1'b0, 1'b0, 1'b1);
            begin
                repeat (35) @(posedge clk);
                wr(SRX_ADDR_CTRL, 8'h0C);
            end
        join
        rd(SRX_ADDR_CTRL, 8'h14);
        rd(SRX_ADDR_IFAC, 8'h04);
        report_and_stop();
    end
endmodule // srx_top_test
